/* File: core/lsw_fifo.sv */
// Purpose: Small valid/ready FIFO in the display data path.
// Assumes: Single clock, asynchronous active-high reset.
// Notes: Depth must be a power of two; full and empty are exact.
`default_nettype none
module lsw_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_q;
  logic [AW:0] rd_q;
  logic push;
  logic pop;

  assign in_ready = (wr_q - rd_q) != (AW+1)'(DEPTH);
  assign out_valid = wr_q != rd_q;
  assign out_data = mem[rd_q[AW-1:0]];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      wr_q <= '0;
      rd_q <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop)
      begin
        rd_q <= rd_q + 1'b1;
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (push)
    begin
      mem[wr_q[AW-1:0]] <= in_data;
    end
  end

  a_fifo_no_overrun : assert property (@(posedge mclk) disable iff (rst)
    (wr_q - rd_q) <= (AW+1)'(DEPTH))
    else $error("FIFO holds more words than its depth.");
endmodule : lsw_fifo
`default_nettype wire

/* File: core/lsw_router.sv */
// Purpose: Routes eight high-speed lanes onto the display inputs and tracks the on/off mode.
// Assumes: Inputs synchronous to mclk; serialiser and flash controller sit outside.
// Notes: The swap selection is latched only between frames so a frame never changes mapping.
`default_nettype none
module lsw_router
  import lsw_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Mode control pin and software selection
  input wire logic projector_on_request,
  input wire logic swap_select,
  // Firmware fetch handshake with the flash reader
  input wire logic fw_reload_request,
  output logic fw_fetch_req,
  input wire logic fw_fetch_done,
  // Lane data from the formatter, one bit per lane per clock
  input wire logic src_valid,
  output logic src_ready,
  input wire logic [LSW_LANES-1:0] src_lanes,
  input wire logic src_last,
  // Display side differential lanes, index i is display input i
  output logic [LSW_LANES-1:0] dmd_data_pos,
  output logic [LSW_LANES-1:0] dmd_data_neg,
  output logic dmd_data_valid,
  // Status
  output logic powered_on,
  output logic swap_active
);
  typedef struct packed
  {
    lsw_mode_t mode;
    logic swap;
    logic in_frame;
    logic fetch;
    logic [LSW_LANES-1:0] pos;
    logic [LSW_LANES-1:0] neg;
    logic valid;
    logic on;
  } lsw_state_t;

  // Several paths gate on the on mode; one decoder keeps them in step.
  function automatic logic lsw_mode_is_on(input lsw_mode_t mode);
    return mode == LSW_ON;
  endfunction : lsw_mode_is_on

  lsw_state_t s_q;
  lsw_state_t s_d;
  lsw_beat_t fifo_in;
  lsw_beat_t fifo_out;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic fifo_in_ready;
  logic fifo_in_valid;

  // Data is only taken while on; off mode holds the input stalled.
  // Ready comes from a flop; while on the FIFO drains every cycle, so it never holds more than one word.
  assign fifo_in_valid = src_valid && s_q.on && fifo_in_ready;
  assign src_ready = s_q.on;
  assign fifo_in.lanes = src_lanes;
  assign fifo_in.last = src_last;
  assign fifo_out_ready = lsw_mode_is_on(s_q.mode);

  lsw_fifo #(
    .WIDTH($bits(lsw_beat_t)),
    .DEPTH(LSW_FIFO_DEPTH)
  ) u_fifo (
    .mclk(mclk),
    .rst(rst),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out)
  );

  always_comb
  begin
    logic [2:0] src;
    logic beat;
    logic use_swap;
    src = '0;
    beat = 1'b0;
    use_swap = 1'b0;
    s_d = s_q;
    beat = fifo_out_valid && fifo_out_ready;
    s_d.valid = 1'b0;
    // The host's I2C command path lands on swap_select; it is taken between frames only.
    // Latching on every idle cycle, the opening beat included, keeps a frame on the mapping it began with.
    if (!s_q.in_frame)
    begin
      s_d.swap = swap_select;
    end
    use_swap = s_q.in_frame ? s_q.swap : swap_select;
    if (beat)
    begin
      s_d.in_frame = !fifo_out.last;
      s_d.valid = 1'b1;
      for (int i = 0; i < LSW_LANES; i++)
      begin
        src = lsw_src_lane(use_swap, 3'(i));
        s_d.pos[i] = fifo_out.lanes[src];
        s_d.neg[i] = !fifo_out.lanes[src];
      end
    end
    if (fw_reload_request && lsw_mode_is_on(s_q.mode))
    begin
      s_d.fetch = 1'b1;
    end
    unique case (s_q.mode)
      LSW_OFF:
      begin
        // Idle lanes sit at a defined differential zero to avoid toggling.
        s_d.pos = '0;
        s_d.neg = '1;
        s_d.in_frame = 1'b0;
        if (projector_on_request)
        begin
          s_d.mode = LSW_BOOT;
          s_d.fetch = 1'b1;
        end
      end
      LSW_BOOT:
      begin
        // Boot must finish even if the pin drops; the firmware is needed to park safely.
        if (fw_fetch_done)
        begin
          s_d.fetch = 1'b0;
          s_d.mode = projector_on_request ? LSW_ON : LSW_OFF;
        end
      end
      LSW_ON:
      begin
        // A reload that meets the end of a fetch wins, so the new request is not lost.
        if (fw_fetch_done && !fw_reload_request)
        begin
          s_d.fetch = 1'b0;
        end
        if (!projector_on_request)
        begin
          s_d.mode = LSW_OFF;
          s_d.fetch = 1'b0;
        end
      end
      default:
      begin
        s_d.mode = LSW_OFF;
      end
    endcase
    s_d.on = lsw_mode_is_on(s_d.mode);
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      s_q.mode <= LSW_OFF;
      s_q.swap <= LSW_SWAP_RESET;
      s_q.in_frame <= 1'b0;
      s_q.fetch <= 1'b0;
      s_q.pos <= '0;
      s_q.neg <= '1;
      s_q.valid <= 1'b0;
      s_q.on <= 1'b0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign dmd_data_pos = s_q.pos;
  assign dmd_data_neg = s_q.neg;
  assign dmd_data_valid = s_q.valid;
  assign powered_on = s_q.on;
  assign swap_active = s_q.swap;
  assign fw_fetch_req = s_q.fetch;

  // Steps of the power-up handshake, shared by the mode assertions below.
  sequence s_power_request;
    s_q.mode == LSW_OFF && projector_on_request;
  endsequence

  sequence s_boot_started;
    s_q.mode == LSW_BOOT && fw_fetch_req;
  endsequence

  sequence s_fetch_finished;
    s_q.mode == LSW_BOOT && fw_fetch_done;
  endsequence

  a_swap_frame_hold : assert property (@(posedge mclk) disable iff (rst)
    s_q.in_frame |=> $stable(s_q.swap))
    else $error("Swap selection changed inside a frame.");

  a_opt1_lane_map : assert property (@(posedge mclk) disable iff (rst)
    (fifo_out_valid && fifo_out_ready && !(s_q.in_frame ? s_q.swap : swap_select))
    |=> (dmd_data_pos[0] == $past(fifo_out.lanes[3]) && dmd_data_pos[4] == $past(fifo_out.lanes[7])))
    else $error("Option one mapping wrong.");

  a_opt2_lane_map : assert property (@(posedge mclk) disable iff (rst)
    (fifo_out_valid && fifo_out_ready && (s_q.in_frame ? s_q.swap : swap_select))
    |=> (dmd_data_pos[0] == $past(fifo_out.lanes[4]) && dmd_data_pos[7] == $past(fifo_out.lanes[3])))
    else $error("Option two mapping wrong.");

  a_pair_complement : assert property (@(posedge mclk) disable iff (rst)
    dmd_data_valid |-> (dmd_data_neg == ~dmd_data_pos))
    else $error("Lane pair legs not complementary.");

  a_on_boots : assert property (@(posedge mclk) disable iff (rst)
    s_power_request |=> s_boot_started)
    else $error("Projector-on did not start boot.");

  a_off_quiet : assert property (@(posedge mclk) disable iff (rst)
    (s_q.mode == LSW_ON && !projector_on_request) |=> (!powered_on ##1 !dmd_data_valid))
    else $error("Off mode still sends data.");

  a_no_data_off : assert property (@(posedge mclk) disable iff (rst)
    !powered_on |=> !dmd_data_valid)
    else $error("Lanes delivered a beat while not on.");

  a_reload_fetch : assert property (@(posedge mclk) disable iff (rst)
    (powered_on && fw_reload_request && projector_on_request) |=> fw_fetch_req)
    else $error("Reload did not request firmware.");

  a_boot_to_on : assert property (@(posedge mclk) disable iff (rst)
    (s_fetch_finished ##0 projector_on_request) |=> (powered_on && !fw_fetch_req))
    else $error("Finished boot did not reach on mode.");

  a_boot_to_off : assert property (@(posedge mclk) disable iff (rst)
    (s_fetch_finished ##0 !projector_on_request) |=> (s_q.mode == LSW_OFF && !fw_fetch_req))
    else $error("Boot with the pin low did not return to off.");

  a_boot_waits : assert property (@(posedge mclk) disable iff (rst)
    (s_boot_started ##0 !fw_fetch_done) |=> s_boot_started)
    else $error("Boot left before the fetch finished.");

  a_off_lanes_idle : assert property (@(posedge mclk) disable iff (rst)
    (s_q.mode == LSW_OFF) |=> (dmd_data_pos == '0 && dmd_data_neg == '1 && !dmd_data_valid))
    else $error("Lanes not parked in off mode.");

  a_beat_out : assert property (@(posedge mclk) disable iff (rst)
    (fifo_out_valid && fifo_out_ready) |=> dmd_data_valid)
    else $error("Popped beat was not delivered.");

  a_no_stray_beat : assert property (@(posedge mclk) disable iff (rst)
    !(fifo_out_valid && fifo_out_ready) |=> !dmd_data_valid)
    else $error("Beat delivered without a popped word.");

  a_fetch_holds : assert property (@(posedge mclk) disable iff (rst)
    (powered_on && fw_fetch_req && !fw_fetch_done && projector_on_request) |=> fw_fetch_req)
    else $error("Fetch request dropped before done.");

  a_swap_idle_track : assert property (@(posedge mclk) disable iff (rst)
    !s_q.in_frame |=> (swap_active == $past(swap_select)))
    else $error("Swap selection not taken between frames.");

  a_ready_room : assert property (@(posedge mclk) disable iff (rst)
    src_ready |-> fifo_in_ready)
    else $error("Ready offered while the FIFO is full.");

  a_opt1_lane_more : assert property (@(posedge mclk) disable iff (rst)
    (fifo_out_valid && fifo_out_ready && !(s_q.in_frame ? s_q.swap : swap_select))
    |=> (dmd_data_pos[3] == $past(fifo_out.lanes[0]) && dmd_data_pos[7] == $past(fifo_out.lanes[4])))
    else $error("Option one upper mapping wrong.");

  a_opt2_lane_more : assert property (@(posedge mclk) disable iff (rst)
    (fifo_out_valid && fifo_out_ready && (s_q.in_frame ? s_q.swap : swap_select))
    |=> (dmd_data_pos[3] == $past(fifo_out.lanes[7]) && dmd_data_pos[4] == $past(fifo_out.lanes[0])))
    else $error("Option two upper mapping wrong.");

  a_frame_opens : assert property (@(posedge mclk) disable iff (rst)
    (fifo_out_valid && fifo_out_ready && !fifo_out.last) |=> s_q.in_frame)
    else $error("Frame did not open on a non-final beat.");

  a_frame_closes : assert property (@(posedge mclk) disable iff (rst)
    (fifo_out_valid && fifo_out_ready && fifo_out.last) |=> !s_q.in_frame)
    else $error("Frame did not close on its final beat.");
endmodule : lsw_router
`default_nettype wire

/* File: include/lsw_pkg.sv */
// Purpose: Shared types and constants for the display lane router and power mode control.
// Assumes: One 40 MHz clock; all inputs synchronous to it.
// Notes: Lane words are one bit per lane per clock, the negative leg being its inverse; serialisation happens elsewhere.
`default_nettype none
package lsw_pkg;
  localparam int LSW_LANES = 8;
  localparam int LSW_FIFO_DEPTH = 4;
  localparam int LSW_FIFO_AW = 2;

  // Lane indices A..H.
  localparam logic [2:0] LSW_LANE_A = 3'h0;
  localparam logic [2:0] LSW_LANE_B = 3'h1;
  localparam logic [2:0] LSW_LANE_C = 3'h2;
  localparam logic [2:0] LSW_LANE_D = 3'h3;
  localparam logic [2:0] LSW_LANE_E = 3'h4;
  localparam logic [2:0] LSW_LANE_F = 3'h5;
  localparam logic [2:0] LSW_LANE_G = 3'h6;
  localparam logic [2:0] LSW_LANE_H = 3'h7;

  localparam logic LSW_SWAP_RESET = 1'h0;
  localparam logic [3:0] LSW_FLASH_WORDS = 4'h8;

  typedef enum logic [1:0]
  {
    LSW_OFF = 2'b00,
    LSW_BOOT = 2'b01,
    LSW_ON = 2'b10
  } lsw_mode_t;

  // One data beat for the display: eight lane values plus an end-of-frame marker.
  typedef struct packed
  {
    logic [LSW_LANES-1:0] lanes;
    logic last;
  } lsw_beat_t;

  typedef struct packed
  {
    logic [LSW_LANES-1:0] pos;
    logic [LSW_LANES-1:0] neg;
  } lsw_pair_t;

  // Display input i in option one is driven from lane D,C,B,A,H,G,F,E.
  function automatic logic [2:0] lsw_src_lane(input logic swap, input logic [2:0] idx);
    logic [2:0] opt1;
    opt1 = (idx < 3'h4) ? 3'(LSW_LANE_D - idx) : 3'(LSW_LANE_H - (idx - 3'h4));
    return swap ? 3'(3'h7 - opt1) : opt1;
  endfunction : lsw_src_lane
endpackage : lsw_pkg
`default_nettype wire

/* File: verification/lsw_dmd_model.sv */
// Purpose: Behavioural display receiver for the eight lane pairs.
// Assumes: Lanes are sampled on the rising mclk edge while valid is high.
// Notes: A beat whose negative legs are not the inverse of its positive legs is counted.
`default_nettype none
module lsw_dmd_model
  import lsw_pkg::*;
(
  // Clock
  input wire logic mclk,
  // Display inputs
  input wire logic [LSW_LANES-1:0] data_pos,
  input wire logic [LSW_LANES-1:0] data_neg,
  input wire logic data_valid,
  // Captured beat
  output logic rx_valid,
  output logic [LSW_LANES-1:0] rx_word,
  output int pair_errs
);
  timeunit 1ns;
  timeprecision 1ps;
  initial pair_errs = 0;
  always @(posedge mclk)
  begin
    rx_valid <= data_valid;
    rx_word <= data_pos;
    if (data_valid === 1'b1 && data_neg !== ~data_pos)
      pair_errs <= pair_errs + 1;
  end
endmodule : lsw_dmd_model
`default_nettype wire

/* File: verification/lsw_router_tb.sv */
// Purpose: Self-checking bench for the lane router and its on/off mode.
// Assumes: Inputs change on the falling edge of a 40 MHz clock.
// Notes: Frames carry random lane words; swap is toggled inside frames on purpose.
`default_nettype none
module lsw_router_tb;
  import lsw_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic pin = 1'b0;
  logic swap_sel = 1'b0;
  logic reload = 1'b0;
  logic done = 1'b0;
  logic fetch_req, src_ready, dvalid, powered_on, swap_active, rx_valid;
  logic src_valid = 1'b0;
  logic src_last = 1'b0;
  logic [7:0] src_lanes = 8'h00;
  logic [7:0] dpos, dneg, rx_word;
  logic [7:0] exp_q[$];
  int pair_errs;
  int err_count = 0;
  int tests_run = 0;
  int seed = 2359;
  always #12.5 mclk = ~mclk;
  lsw_router dut (.mclk(mclk), .rst(rst), .projector_on_request(pin), .swap_select(swap_sel),
    .fw_reload_request(reload), .fw_fetch_req(fetch_req), .fw_fetch_done(done),
    .src_valid(src_valid), .src_ready(src_ready), .src_lanes(src_lanes), .src_last(src_last),
    .dmd_data_pos(dpos), .dmd_data_neg(dneg), .dmd_data_valid(dvalid),
    .powered_on(powered_on), .swap_active(swap_active));
  lsw_dmd_model model (.mclk(mclk), .data_pos(dpos), .data_neg(dneg), .data_valid(dvalid),
    .rx_valid(rx_valid), .rx_word(rx_word), .pair_errs(pair_errs));
  // Display input i takes lane 3-i or 11-i in option one, the mirror in option two.
  function automatic logic [7:0] exp_word(input logic [7:0] l, input logic sw);
    int s;
    for (int i = 0; i < 8; i++)
    begin
      s = (i < 4) ? 3 - i : 11 - i;
      exp_word[i] = l[sw ? 7 - s : s];
    end
  endfunction : exp_word
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic end_of_test;
    $display("errors=%0d comparisons=%0d", err_count, tests_run);
    if (err_count == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_of_test
  task automatic wait_fetch;
    int n;
    n = 0;
    do
    begin
      @(negedge mclk);
      n++;
    end
    while (fetch_req !== 1'b1 && n < 20);
    chk({7'h0, fetch_req}, 8'h01);
    done <= 1'b1;
    @(negedge mclk);
    done <= 1'b0;
    chk({6'h0, powered_on, fetch_req}, 8'h02);
  endtask : wait_fetch
  task automatic power_up;
    @(negedge mclk);
    pin <= 1'b1;
    wait_fetch();
  endtask : power_up
  task automatic send_beat(input logic [7:0] l, input logic last, input logic sw);
    int n;
    @(negedge mclk);
    src_valid <= 1'b1;
    src_lanes <= l;
    src_last <= last;
    swap_sel <= sw;
    n = 0;
    #1;
    while (src_ready !== 1'b1 && n < 50)
    begin
      @(negedge mclk);
      #1;
      n++;
    end
    if (n == 50)
      chk({7'h0, src_ready}, 8'h01);
    @(posedge mclk);
  endtask : send_beat
  task automatic send_frame(input int len, input logic sw, input logic flip);
    logic [7:0] l;
    for (int k = 0; k < len; k++)
    begin
      l = $random(seed);
      exp_q.push_back(exp_word(l, sw));
      // The second beat's selection is still live when the first beat leaves the FIFO, so flips start later.
      send_beat(l, k == len - 1, (k > 1 && flip) ? ~sw : sw);
    end
    @(negedge mclk);
    src_valid <= 1'b0;
    swap_sel <= sw;
  endtask : send_frame
  always @(negedge mclk)
    if (rx_valid === 1'b1)
    begin
      if (exp_q.size() == 0)
        chk({7'h0, rx_valid}, 8'h00);
      else
        chk(rx_word, exp_q.pop_front());
    end
  initial
  begin
    #(25ns * 20000);
    err_count++;
    end_of_test();
  end
  initial
  begin
    logic sw;
    repeat (6) @(posedge mclk);
    @(negedge mclk);
    chk(dneg, 8'hFF);
    chk({dpos[6:0], powered_on}, 8'h00);
    chk({5'h0, src_ready, fetch_req, swap_active}, 8'h00);
    rst <= 1'b0;
    power_up();
    for (int f = 0; f < 8; f++)
    begin
      sw = $random(seed);
      send_frame(f < 2 ? 1 : 1 + ($unsigned($random(seed)) % 8), f < 2 ? f[0] : sw, f > 3);
      repeat (8) @(negedge mclk);
      chk({7'h0, swap_active}, {7'h0, f < 2 ? f[0] : sw});
    end
    chk(exp_q.size(), 8'h00);
    chk(pair_errs, 8'h00);
    @(negedge mclk);
    reload <= 1'b1;
    @(negedge mclk);
    reload <= 1'b0;
    wait_fetch();
    pin <= 1'b0;
    @(negedge mclk);
    src_valid <= 1'b1;
    @(negedge mclk);
    chk({6'h0, powered_on, src_ready}, 8'h00);
    repeat (5) @(negedge mclk);
    chk({7'h0, src_ready}, 8'h00);
    src_valid <= 1'b0;
    power_up();
    send_frame(3, 1'b1, 1'b0);
    repeat (10) @(negedge mclk);
    chk(exp_q.size(), 8'h00);
    // Power down, then drop the pin in the middle of a boot: boot finishes and lands in off mode.
    pin <= 1'b0;
    @(negedge mclk);
    pin <= 1'b1;
    @(negedge mclk);
    pin <= 1'b0;
    @(negedge mclk);
    chk({6'h0, powered_on, fetch_req}, 8'h01);
    done <= 1'b1;
    @(negedge mclk);
    done <= 1'b0;
    chk({6'h0, powered_on, fetch_req}, 8'h00);
    end_of_test();
  end
endmodule : lsw_router_tb
`default_nettype wire
